// *** frame_assembler_pkg.sv ***
// Constants, register map and types of the sensor data frame assembler
package frame_assembler_pkg;

    // ------------------------------------------------------------------
    // Clock and bit timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          BIT_TIME_NS   = 8000;
    localparam logic [15:0] BIT_CYCLES    = 16'(BIT_TIME_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG     = 8'h00;
    localparam logic [7:0] ADDR_SAMPLE     = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_LAST_FRAME = 8'h0C;
    localparam logic [7:0] ADDR_BIT_PERIOD = 8'h10;

    // ------------------------------------------------------------------
    // Field layout and codes
    // ------------------------------------------------------------------
    localparam int          CFG_W        = 6;
    localparam int          SAMPLE_W     = 14;
    localparam int          FRAME_W      = 18;
    localparam int          MSG_W        = 16;
    localparam logic [4:0]  LEN_MIN      = 5'd11;
    localparam logic [4:0]  LEN_MAX      = 5'd18;
    localparam logic [4:0]  CRC_LEN      = 5'd3;
    localparam logic [4:0]  PAR_LEN      = 5'd1;
    localparam logic [2:0]  CRC_POLY     = 3'h3;
    localparam logic [1:0]  START_MODE0  = 2'h2;
    localparam logic [1:0]  START_MODE1  = 2'h1;
    localparam logic [2:0]  SV_STATUS    = 3'h6;
    localparam logic [9:0]  CFG_ERR_CODE = 10'h3C0;
    localparam logic [9:0]  POS_RED_10   = 10'h1D0;
    localparam logic [9:0]  NEG_RED_10   = 10'h230;
    localparam logic [7:0]  POS_RED_8    = 8'h74;
    localparam logic [7:0]  NEG_RED_8    = 8'h8C;
    localparam logic [4:0]  STAT_LEN_LSB = 5'd8;

    // Configuration bits
    typedef struct packed {
        logic device_mode_zero;
        logic line_code_select;
        logic offset_nulling_on;
        logic sample_width_select;
        logic frame_tag_off;
        logic check_kind_select;
    } cfg_t;

    localparam cfg_t CFG_RESET = cfg_t'(6'h20);

    // One queued sample
    typedef struct packed {
        logic       config_data;
        logic [2:0] state_code;
        logic [9:0] value;
    } sample_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND,
        TX_STOP
    } tx_state_t;

endpackage

// *** frame_check_calc.sv ***
// Three-bit CRC and even parity over the message bits of one frame
`timescale 1ns/1ns
module frame_check_calc (
    // Message, left aligned, and its length in bits
    input  wire logic [15:0] msg,
    input  wire logic [4:0]  msg_len,
    // Check values
    output logic      [2:0]  crc,
    output logic             parity
);

    // ------------------------------------------------------------------
    // Shift register from zero, MSB first: message times x^3 modulo the generator
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] r;
        logic       fb;
        r      = 3'h0;
        fb     = 1'b0;
        parity = 1'b0;
        for (int i = 0; i < frame_assembler_pkg::MSG_W; i++) begin
            if (5'(i) < msg_len) begin
                fb     = msg[frame_assembler_pkg::MSG_W - 1 - i] ^ r[2];
                r      = {r[1:0], 1'b0} ^ (fb ? frame_assembler_pkg::CRC_POLY : 3'h0);
                parity = parity ^ msg[frame_assembler_pkg::MSG_W - 1 - i];
            end
        end
        crc = r;
    end

endmodule // frame_check_calc

// *** frame_receiver.sv ***
// Receiver model that collects frame bits from the serial output
`timescale 1ns/1ns
module frame_receiver (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Serial line
    input  wire logic        tx_bit,
    input  wire logic        tx_enable,
    input  wire logic        tx_bit_strobe,
    // Collected frame
    output logic      [17:0] frame,
    output logic      [4:0]  len,
    output logic      [15:0] gap,
    output logic             done
);
    // ------------------------------------------------------------------
    // Bit capture
    // ------------------------------------------------------------------
    logic        was_on;
    logic [15:0] idle;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {frame, len, gap, done, was_on, idle} <= '0;
        end else begin
            was_on <= tx_enable;
            done   <= was_on && !tx_enable;
            idle   <= tx_enable ? 16'h0000 : idle + 16'h0001;
            if (tx_enable && !was_on) gap <= idle;
            if (tx_enable && tx_bit_strobe) begin
                // The first start bit opens a fresh frame
                frame <= was_on ? {frame[16:0], tx_bit} : {17'h00000, tx_bit};
                len   <= was_on ? len + 5'h01 : 5'h01;
            end
        end
    end
endmodule // frame_receiver

// *** sensor_data_frame_assembler.sv ***
// Sensor data frame assembler with APB registers and serial bit output
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module sensor_data_frame_assembler (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial frame output
    output logic             tx_bit,
    output logic             tx_enable,
    output logic             tx_bit_strobe
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    frame_assembler_pkg::cfg_t    cfg, next_cfg;
    frame_assembler_pkg::sample_t sample, next_sample;
    logic                         pend, next_pend;
    logic [15:0]                  bit_period, next_bit_period;
    logic [17:0]                  last_frame, next_last_frame;
    logic [4:0]                   last_len, next_last_len;
    logic [31:0]                  next_prdata;
    logic                         next_pready, next_pslverr;

    // Transmit state
    frame_assembler_pkg::tx_state_t state, next_state;
    logic [17:0]                    shreg, next_shreg;
    logic [4:0]                     bits_left, next_bits_left;
    logic [15:0]                    div, next_div;
    logic                           next_tx_enable, next_tx_strobe;

    // ------------------------------------------------------------------
    // Frame composition
    // ------------------------------------------------------------------
    logic        full_range, cfg_error, sv_on, w8, use_crc, load;
    logic [1:0]  start_bits;
    logic [2:0]  sv_code, crc;
    logic [9:0]  d10;
    logic [7:0]  d8;
    logic [15:0] msg;
    logic [4:0]  msg_len, frame_len;
    logic [17:0] frame;
    logic        parity;

    assign full_range = !cfg.frame_tag_off && !cfg.offset_nulling_on;
    assign cfg_error  = cfg.device_mode_zero && cfg.frame_tag_off;
    assign sv_on      = !cfg.frame_tag_off;
    assign w8         = cfg.sample_width_select;
    assign use_crc    = !cfg.check_kind_select;
    assign start_bits = cfg.line_code_select ? frame_assembler_pkg::START_MODE1
                                             : frame_assembler_pkg::START_MODE0;
    assign load       = (state == frame_assembler_pkg::TX_IDLE) && pend;

    always_comb begin
        logic signed [9:0] sv10;
        logic signed [7:0] sv8;
        sv10    = signed'(sample.value);
        sv8     = signed'(sample.value[9:2]);
        sv_code = sample.state_code;
        d10     = sample.value;
        d8      = sample.value[9:2];
        if (sample.config_data) begin
            d10 = {sample.value[7:0], 2'h0};
            d8  = sample.value[7:0];
        end else if (cfg_error) begin
            sv_code = frame_assembler_pkg::SV_STATUS;
            d10     = frame_assembler_pkg::CFG_ERR_CODE;
            d8      = frame_assembler_pkg::CFG_ERR_CODE[9:2];
        end else if (!full_range) begin
            if (sv10 > signed'(frame_assembler_pkg::POS_RED_10)) begin
                d10 = frame_assembler_pkg::POS_RED_10;
            end else if (sv10 < signed'(frame_assembler_pkg::NEG_RED_10)) begin
                d10 = frame_assembler_pkg::NEG_RED_10;
            end
            if (sv8 > signed'(frame_assembler_pkg::POS_RED_8)) begin
                d8 = frame_assembler_pkg::POS_RED_8;
            end else if (sv8 < signed'(frame_assembler_pkg::NEG_RED_8)) begin
                d8 = frame_assembler_pkg::NEG_RED_8;
            end
        end
    end

    // Message without check field, left aligned
    always_comb begin
        case ({sv_on, w8})
            2'b10: begin
                msg     = {start_bits, sv_code, d10, 1'b0};
                msg_len = 5'd15;
            end
            2'b11: begin
                msg     = {start_bits, sv_code, d8, 3'h0};
                msg_len = 5'd13;
            end
            2'b00: begin
                msg     = {start_bits, d10, 4'h0};
                msg_len = 5'd12;
            end
            default: begin
                msg     = {start_bits, d8, 6'h0};
                msg_len = 5'd10;
            end
        endcase
    end

    frame_check_calc u_check (
        .msg     (msg),
        .msg_len (msg_len),
        .crc     (crc),
        .parity  (parity)
    );

    always_comb begin
        if (use_crc) begin
            frame     = {msg[15:14], crc, msg[13:1]};
            frame_len = msg_len + frame_assembler_pkg::CRC_LEN;
        end else begin
            frame                = {msg, 2'h0};
            frame[5'd17 - msg_len] = parity;
            frame_len            = msg_len + frame_assembler_pkg::PAR_LEN;
        end
    end

    // ------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------
    always_comb begin
        logic wr;
        wr              = psel && penable && pready && pwrite;
        next_cfg        = cfg;
        next_sample     = sample;
        next_pend       = pend && !load;
        next_bit_period = bit_period;
        next_last_frame = load ? frame : last_frame;
        next_last_len   = load ? frame_len : last_len;
        next_pready     = psel && penable && !pready;
        next_pslverr    = 1'b0;
        next_prdata     = 32'h0;
        if (next_pready) begin
            case (paddr)
                frame_assembler_pkg::ADDR_CONFIG:     next_prdata = 32'(cfg);
                frame_assembler_pkg::ADDR_SAMPLE:     next_prdata = 32'(sample);
                frame_assembler_pkg::ADDR_STATUS: begin
                    next_prdata = {19'h0, last_len, 5'h0, full_range, cfg_error,
                                   pend || (state != frame_assembler_pkg::TX_IDLE)};
                end
                frame_assembler_pkg::ADDR_LAST_FRAME: next_prdata = 32'(last_frame);
                frame_assembler_pkg::ADDR_BIT_PERIOD: next_prdata = 32'(bit_period);
                default:                              next_pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                frame_assembler_pkg::ADDR_CONFIG: begin
                    next_cfg = frame_assembler_pkg::cfg_t'(pwdata[5:0]);
                end
                frame_assembler_pkg::ADDR_SAMPLE: begin
                    next_sample = frame_assembler_pkg::sample_t'(pwdata[13:0]);
                    next_pend   = 1'b1;
                end
                frame_assembler_pkg::ADDR_BIT_PERIOD: begin
                    next_bit_period = (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg        <= frame_assembler_pkg::CFG_RESET;
            sample     <= '0;
            pend       <= 1'b0;
            bit_period <= frame_assembler_pkg::BIT_CYCLES;
            last_frame <= 18'h0;
            last_len   <= 5'h0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            cfg        <= next_cfg;
            sample     <= next_sample;
            pend       <= next_pend;
            bit_period <= next_bit_period;
            last_frame <= next_last_frame;
            last_len   <= next_last_len;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Bit serialiser
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_shreg     = shreg;
        next_bits_left = bits_left;
        next_div       = div;
        next_tx_enable = tx_enable;
        next_tx_strobe = 1'b0;
        case (state)
            frame_assembler_pkg::TX_IDLE: begin
                if (load) begin
                    next_state     = frame_assembler_pkg::TX_SEND;
                    next_shreg     = frame;
                    next_bits_left = frame_len;
                    next_div       = bit_period - 16'h1;
                    next_tx_enable = 1'b1;
                    next_tx_strobe = 1'b1;
                end
            end
            frame_assembler_pkg::TX_SEND: begin
                if (div == 16'h0) begin
                    next_shreg = {shreg[16:0], 1'b0};
                    next_div   = bit_period - 16'h1;
                    if (bits_left == 5'h1) begin
                        next_state     = frame_assembler_pkg::TX_STOP;
                        next_tx_enable = 1'b0;
                    end else begin
                        next_bits_left = bits_left - 5'h1;
                        next_tx_strobe = 1'b1;
                    end
                end else begin
                    next_div = div - 16'h1;
                end
            end
            frame_assembler_pkg::TX_STOP: begin
                if (div == 16'h0) begin
                    next_state = frame_assembler_pkg::TX_IDLE;
                end else begin
                    next_div = div - 16'h1;
                end
            end
            default: next_state = frame_assembler_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= frame_assembler_pkg::TX_IDLE;
            shreg         <= 18'h0;
            bits_left     <= 5'h0;
            div           <= 16'h0;
            tx_enable     <= 1'b0;
            tx_bit_strobe <= 1'b0;
        end else begin
            state         <= next_state;
            shreg         <= next_shreg;
            bits_left     <= next_bits_left;
            div           <= next_div;
            tx_enable     <= next_tx_enable;
            tx_bit_strobe <= next_tx_strobe;
        end
    end

    assign tx_bit = shreg[17];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_pair: assert property (load |=> tx_enable && shreg[17:16] == $past(start_bits))
        else $error("frame does not open with the start bit pair");
    a_stop_idle: assert property ($fell(tx_enable) |->
                                  state == frame_assembler_pkg::TX_STOP
                                  && div == $past(bit_period) - 16'h1)
        else $error("no idle bit time after frame");
    a_stop_quiet: assert property (state == frame_assembler_pkg::TX_STOP
                                   |-> !tx_enable && !tx_bit)
        else $error("line not idle during stop bit");
    a_len_range: assert property (load |-> frame_len >= frame_assembler_pkg::LEN_MIN
                                  && frame_len <= frame_assembler_pkg::LEN_MAX)
        else $error("frame length out of range");
    a_len_formula: assert property (load |-> frame_len == 5'd2 + (use_crc ? 5'd3 : 5'd1)
                                    + (sv_on ? 5'd3 : 5'd0) + (w8 ? 5'd8 : 5'd10))
        else $error("frame length does not match settings");
    a_crc_place: assert property (load && use_crc |=> last_frame[15:13] == $past(crc))
        else $error("CRC not right after start bits");
    a_parity_even: assert property (load && !use_crc |-> ^frame == 1'b0)
        else $error("frame parity not even");
    a_range_select: assert property (load && full_range && !sample.config_data
                                     |-> d10 == sample.value && d8 == sample.value[9:2])
        else $error("full range data altered");
    a_reduced_ten: assert property (load && !full_range && !w8 && !sample.config_data
                                    |-> signed'(d10) <= signed'(frame_assembler_pkg::POS_RED_10)
                                    && signed'(d10) >= signed'(frame_assembler_pkg::NEG_RED_10))
        else $error("ten-bit reduced limit broken");
    a_reduced_eight: assert property (load && !full_range && w8 && !sample.config_data
                                      |-> signed'(d8) <= signed'(frame_assembler_pkg::POS_RED_8)
                                      && signed'(d8) >= signed'(frame_assembler_pkg::NEG_RED_8))
        else $error("eight-bit reduced limit broken");
    a_cfg_error: assert property (load && cfg_error && !sample.config_data
                                  |-> d10 == frame_assembler_pkg::CFG_ERR_CODE)
        else $error("sensor data sent under configuration error");
    a_sv_field: assert property (load && sv_on |-> msg[13:11] == sv_code)
        else $error("state vector missing from frame");

    c_crc_frame: cover property (load && use_crc && sv_on && !w8);
    c_parity_frame: cover property (load && !use_crc && !sv_on && w8);
    c_cfg_error: cover property (load && cfg_error);
    c_stop_end: cover property ($fell(tx_enable) ##[1:300] state == frame_assembler_pkg::TX_IDLE);

endmodule // sensor_data_frame_assembler

// *** sensor_data_frame_assembler_tb.sv ***
// Self-checking testbench of the sensor data frame assembler
`timescale 1ns/1ns
module sensor_data_frame_assembler_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, tx_bit, tx_enable, tx_bit_strobe, r_done;
    logic [17:0] r_frame;
    logic [4:0]  r_len;
    logic [15:0] r_gap;
    int          bad_count = 0;
    int          checked = 0;
    always #20 pclk = ~pclk;
    sensor_data_frame_assembler DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_bit(tx_bit), .tx_enable(tx_enable),
        .tx_bit_strobe(tx_bit_strobe));
    frame_receiver rx (.pclk(pclk), .presetn(presetn), .tx_bit(tx_bit), .tx_enable(tx_enable),
        .tx_bit_strobe(tx_bit_strobe), .frame(r_frame), .len(r_len), .gap(r_gap), .done(r_done));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            chk(32'h0, 32'h1, "apb timeout");
            end_of_test();
        end
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (r_done === 1'b1) break;
        end
        if (i == 3000) begin
            chk(32'h0, 32'h1, "frame timeout");
            end_of_test();
        end
    endtask
    function automatic logic [2:0] crc3(input logic [17:0] m, input int n);
        logic [2:0] r = 3'h0;
        for (int i = n - 1; i >= 0; i--) r = {r[1:0], 1'b0} ^ ((m[i] ^ r[2]) ? 3'h3 : 3'h0);
        return r;
    endfunction
    // Residue of a received CRC frame with the check field moved to the end
    function automatic logic [2:0] crc_residue(input logic [17:0] f, input int n);
        logic [17:0] m;
        m = ((f >> (n - 2)) << (n - 2)) | ((f & ((18'h1 << (n - 5)) - 18'h1)) << 3)
            | ((f >> (n - 5)) & 18'h7);
        return crc3(m, n);
    endfunction
    // Expected frame, right aligned, with its length on top
    function automatic logic [22:0] expect_frame(input logic [5:0] c, input logic [13:0] s);
        logic [17:0] m;
        logic [9:0]  d;
        int          n;
        d = c[2] ? {2'h0, s[9:2]} : s[9:0];
        if (s[13]) d = c[2] ? {2'h0, s[7:0]} : {s[7:0], 2'h0};
        else if (c[5] && c[1]) d = c[2] ? 10'h0F0 : 10'h3C0;
        else if (c[1] || c[3]) begin
            if (c[2] && $signed(d[7:0]) > $signed(8'h74)) d = 10'h074;
            if (c[2] && $signed(d[7:0]) < $signed(8'h8C)) d = 10'h08C;
            if (!c[2] && $signed(d) > $signed(10'h1D0)) d = 10'h1D0;
            if (!c[2] && $signed(d) < $signed(10'h230)) d = 10'h230;
        end
        m = c[4] ? 18'h1 : 18'h2;
        n = c[2] ? 10 : 12;
        if (!c[1]) m = (m << 3) | ((c[5] && c[1]) ? 18'h6 : 18'(s[12:10]));
        if (!c[1]) n += 3;
        m = (m << (c[2] ? 8 : 10)) | 18'(d);
        if (c[0]) return {5'(n + 1), (m << 1) | 18'(^m)};
        return {5'(n + 3), ((m >> (n - 2)) << (n + 1)) | (18'(crc3(m, n)) << (n - 2))
                | (m & ((18'h1 << (n - 2)) - 18'h1))};
    endfunction
    task automatic send(input logic [5:0] c, input logic [13:0] s);
        logic [22:0] e;
        logic [31:0] rd;
        logic        er;
        logic [2:0]  sx;
        e = expect_frame(c, s);
        sx = {!c[1] && !c[3], c[5] && c[1], 1'b0};
        apb(1'b1, frame_assembler_pkg::ADDR_CONFIG, {26'h0, c}, rd, er);
        apb(1'b1, frame_assembler_pkg::ADDR_SAMPLE, {18'h0, s}, rd, er);
        wait_done();
        chk({27'h0, r_len}, {27'h0, e[22:18]}, "length");
        chk({14'h0, r_frame}, {14'h0, e[17:0]}, "frame bits");
        if (!c[0]) chk({29'h0, crc_residue(r_frame, int'(r_len))}, 32'h0, "crc residue");
        apb(1'b0, frame_assembler_pkg::ADDR_LAST_FRAME, 32'h0, rd, er);
        chk(rd, {14'h0, e[17:0] << (18 - e[22:18])}, "last frame");
        apb(1'b0, frame_assembler_pkg::ADDR_STATUS, 32'h0, rd, er);
        chk({24'h0, rd[12:8], rd[2:0]}, {24'h0, e[22:18], sx}, "status");
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, frame_assembler_pkg::ADDR_CONFIG, 32'h0, rd, er);
        chk(rd, 32'h00000020, "config reset");
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error");
        apb(1'b0, frame_assembler_pkg::ADDR_BIT_PERIOD, 32'h0, rd, er);
        chk(rd, 32'(frame_assembler_pkg::BIT_CYCLES), "period reset");
        apb(1'b1, frame_assembler_pkg::ADDR_BIT_PERIOD, 32'h0, rd, er);
        apb(1'b0, frame_assembler_pkg::ADDR_BIT_PERIOD, 32'h0, rd, er);
        chk(rd, 32'h00000001, "period floor");
        apb(1'b1, frame_assembler_pkg::ADDR_BIT_PERIOD, 32'h4, rd, er);
        apb(1'b0, frame_assembler_pkg::ADDR_BIT_PERIOD, 32'h0, rd, er);
        chk(rd, 32'h00000004, "period");
        $display("t_regs done");
    endtask
    task automatic t_formats();
        send(6'h00, 14'h01FF);
        send(6'h01, 14'h0E00);
        send(6'h04, 14'h01FC);
        send(6'h0E, 14'h01FF);
        send(6'h08, 14'h0200);
        send(6'h13, 14'h01D1);
        send(6'h07, 14'h0000);
        send(6'h22, 14'h0100);
        send(6'h00, 14'h20A5);
        send(6'h04, 14'h20A5);
        for (int k = 0; k < 8; k++) send(6'h00, {1'b0, 3'(k), 10'h155});
        $display("t_formats done");
    endtask
    task automatic t_back();
        logic [31:0] rd;
        logic        er;
        apb(1'b1, frame_assembler_pkg::ADDR_SAMPLE, 32'h00000011, rd, er);
        apb(1'b1, frame_assembler_pkg::ADDR_SAMPLE, 32'h00000122, rd, er);
        wait_done();
        chk({14'h0, r_frame}, {14'h0, 18'(expect_frame(6'h00, 14'h0011))}, "1st");
        wait_done();
        chk({31'h0, r_gap >= 16'h0004}, 32'h1, "stop bit gap");
        chk({14'h0, r_frame}, {14'h0, 18'(expect_frame(6'h00, 14'h0122))}, "2nd");
        $display("t_back done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_formats();
        t_back();
        end_of_test();
    end
endmodule // sensor_data_frame_assembler_tb
